// ### inc/pmf_map.vh
// register map, field positions, reset values and codes of the math block
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef PMF_MAP_VH
`define PMF_MAP_VH

// register byte offsets
`define PMF_ADR_CTRL      8'h00
`define PMF_ADR_OPER      8'h04
`define PMF_ADR_OPND0     8'h08
`define PMF_ADR_OPND1     8'h0c
`define PMF_ADR_OPND2     8'h10
`define PMF_ADR_OPND3     8'h14
`define PMF_ADR_RESULT    8'h18
`define PMF_ADR_STATUS    8'h1c

// control register fields
`define PMF_CTRL_W        9
`define PMF_CB_MATH_EN    0
`define PMF_CB_HOLD       1
`define PMF_CB_DET_EN     2
`define PMF_CB_DET_RST    3
`define PMF_CB_FSEL       4
`define PMF_CB_SELF_CLR   6
`define PMF_CB_REF_VALID  7
`define PMF_CB_UNIT_FIRST 8
`define PMF_CTRL_RST      9'h000

// operator register fields: op k at 2k, priority k at 6+2k
`define PMF_OPER_W        12
`define PMF_OB_PRIO       6
`define PMF_OPER_RST      12'h180

// status register fields
`define PMF_SB_ZD         0
`define PMF_SB_OF         1
`define PMF_SB_FAULT      2
`define PMF_SB_BUSY       3

// operator codes
`define PMF_OP_ADD        2'h0
`define PMF_OP_SUB        2'h1
`define PMF_OP_MUL        2'h2
`define PMF_OP_DIV        2'h3

// priority codes
`define PMF_PR_LOW        2'h0
`define PMF_PR_MED        2'h1
`define PMF_PR_HIGH       2'h2

// fault selector codes
`define PMF_FS_ZD         2'h0
`define PMF_FS_OF         2'h1
`define PMF_FS_BOTH       2'h2

// saturation limits
`define PMF_SAT_MAX       16'h7fff
`define PMF_SAT_MIN       16'h8000

// cycles from scan tick until result and flags are updated
`define PMF_EVAL_LAT      5
`define PMF_SCAN_CYCLES   16

`endif

// ### hdl/pmf_op_unit.v
// one binary operation on 16-bit signed values, rounded and saturated
// assumes purely combinational use by the evaluation sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pmf_map.vh"

module pmf_op_unit (
    input  wire [15:0] opa_i,
    input  wire [15:0] opb_i,
    input  wire [1:0]  opsel_i,
    output reg  [15:0] res_o,
    output reg         zdiv_o,
    output reg         ovf_o
);

    reg signed [32:0] a_x;
    reg signed [32:0] b_x;
    reg signed [32:0] full;
    reg        [16:0] mag_a;
    reg        [16:0] mag_b;
    reg        [18:0] quo;

    always @* begin
        a_x    = {{17{opa_i[15]}}, opa_i};
        b_x    = {{17{opb_i[15]}}, opb_i};
        mag_a  = opa_i[15] ? (17'h00000 - {opa_i[15], opa_i}) : {1'b0, opa_i};
        mag_b  = opb_i[15] ? (17'h00000 - {opb_i[15], opb_i}) : {1'b0, opb_i};
        quo    = 19'h00000;
        zdiv_o = 1'b0;
        case (opsel_i)
            `PMF_OP_ADD: full = a_x + b_x;
            `PMF_OP_SUB: full = a_x - b_x;
            `PMF_OP_MUL: full = a_x * b_x;
            default: begin
                if (opb_i == 16'h0000) begin
                    zdiv_o = 1'b1;
                    full   = 33'h000007fff;
                end else begin
                    // nearest integer, halves away from zero
                    quo  = ({1'b0, mag_a, 1'b0} + {2'b00, mag_b}) / {1'b0, mag_b, 1'b0};
                    full = (opa_i[15] ^ opb_i[15]) ? (33'h000000000 - {14'h0000, quo})
                                                   : {14'h0000, quo};
                end
            end
        endcase
        // saturate to the 16-bit range
        if (full > 33'sh000007fff) begin
            ovf_o = ~zdiv_o;
            res_o = `PMF_SAT_MAX;
        end else if (full < -33'sh000008000) begin
            ovf_o = 1'b1;
            res_o = `PMF_SAT_MIN;
        end else begin
            ovf_o = 1'b0;
            res_o = full[15:0];
        end
    end

endmodule // pmf_op_unit

`default_nettype wire

// ### hdl/pmf_math_top.v
// priority math unit with fault detector and wishbone register slave
// assumes one 200 mhz clock; the scan cycle is a divided enable pulse
//
// What this block does
// - unit starts on enable rising edge
// - zero division or overflow gives 32767, underflow -32768
// - out-of-range sourced operands clamp to limits
// - four operands, three selectable operators
// - operations run high, medium, then low
// - result rounded to nearest integer
// - disable setting zero: result zero when off
// - disable setting one: result holds when off
// - flags report each fault per execution
// - detector starts on its enable rising edge
// - selector picks division, overflow, or both
// - no referenced unit keeps detector low
// - self clear clears before each execution
// - without self clear output sticks until reset
// - detector reset clears its output
// - unit order decides same or next scan
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "pmf_map.vh"

module pmf_math_top #(
    parameter SCAN_CYCLES = `PMF_SCAN_CYCLES
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg  [15:0] result_value_o,
    output reg         zero_div_flag_o,
    output reg         overflow_flag_o,
    output reg         fault_o,
    output reg         scan_tick_o
);

    localparam ST_IDLE = 2'd0;
    localparam ST_STEP = 2'd1;
    localparam ST_DONE = 2'd2;

    ////////////////////////////////////////////////////////////////////////////
    // registers and state

    reg [`PMF_CTRL_W-1:0] ctrl;
    reg [`PMF_OPER_W-1:0] oper;
    reg [31:0]            opnd [0:3];
    reg [15:0]            term [0:3];
    reg [1:0]             opr  [0:2];
    reg [1:0]             prio [0:2];
    reg [1:0]             nops;
    reg [1:0]             state;
    reg                   zd_acc;
    reg                   ov_acc;
    reg                   math_en_q;
    reg                   math_act;
    reg                   det_en_q;
    reg                   det_act;
    reg [15:0]            scan_cnt;
    reg [`PMF_EVAL_LAT:0] tick_dly;
    reg [1:0]             pick;
    reg [1:0]             best;
    reg                   fault_sel;
    reg [31:0]            rd_data;

    wire        wb_req;
    wire        wb_wr;
    wire [31:0] ctrl_wr;
    wire [31:0] oper_wr;
    wire [1:0]  pick_nx;
    wire [15:0] op_res;
    wire        op_zd;
    wire        op_ov;
    wire        det_exec;
    wire [1:0]  fsel;

    integer i;
    integer j;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  sel;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                merge[k*8 +: 8] = sel[k] ? new_v[k*8 +: 8] : old_v[k*8 +: 8];
            end
        end
    endfunction

    function [15:0] clamp16;
        input [31:0] v;
        begin
            if ($signed(v) > 32'sh00007fff) begin
                clamp16 = `PMF_SAT_MAX;
            end else if ($signed(v) < -32'sh00008000) begin
                clamp16 = `PMF_SAT_MIN;
            end else begin
                clamp16 = v[15:0];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, ack for one cycle

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr  = wb_req & wb_we_i;
    assign ctrl_wr = merge({{(32-`PMF_CTRL_W){1'b0}}, ctrl}, wb_dat_i, wb_sel_i);
    assign oper_wr = merge({{(32-`PMF_OPER_W){1'b0}}, oper}, wb_dat_i, wb_sel_i);

    always @* begin
        case (wb_adr_i)
            `PMF_ADR_CTRL:   rd_data = {{(32-`PMF_CTRL_W){1'b0}}, ctrl};
            `PMF_ADR_OPER:   rd_data = {{(32-`PMF_OPER_W){1'b0}}, oper};
            `PMF_ADR_OPND0:  rd_data = opnd[0];
            `PMF_ADR_OPND1:  rd_data = opnd[1];
            `PMF_ADR_OPND2:  rd_data = opnd[2];
            `PMF_ADR_OPND3:  rd_data = opnd[3];
            `PMF_ADR_RESULT: rd_data = {{16{result_value_o[15]}}, result_value_o};
            `PMF_ADR_STATUS: rd_data = {28'h0000000, (state != ST_IDLE), fault_o,
                                        overflow_flag_o, zero_div_flag_o};
            default:         rd_data = 32'h00000000;
        endcase
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req & ~wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl    <= `PMF_CTRL_RST;
            oper    <= `PMF_OPER_RST;
            opnd[0] <= 32'h00000000;
            opnd[1] <= 32'h00000000;
            opnd[2] <= 32'h00000000;
            opnd[3] <= 32'h00000000;
        end else if (wb_wr) begin
            case (wb_adr_i)
                `PMF_ADR_CTRL:  ctrl    <= ctrl_wr[`PMF_CTRL_W-1:0];
                `PMF_ADR_OPER:  oper    <= oper_wr[`PMF_OPER_W-1:0];
                `PMF_ADR_OPND0: opnd[0] <= merge(opnd[0], wb_dat_i, wb_sel_i);
                `PMF_ADR_OPND1: opnd[1] <= merge(opnd[1], wb_dat_i, wb_sel_i);
                `PMF_ADR_OPND2: opnd[2] <= merge(opnd[2], wb_dat_i, wb_sel_i);
                `PMF_ADR_OPND3: opnd[3] <= merge(opnd[3], wb_dat_i, wb_sel_i);
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // scan cycle divider and late tick for detector ordering

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scan_cnt    <= 16'h0000;
            scan_tick_o <= 1'b0;
            tick_dly    <= {(`PMF_EVAL_LAT+1){1'b0}};
        end else begin
            if (scan_cnt == SCAN_CYCLES[15:0] - 16'h0001) begin
                scan_cnt    <= 16'h0000;
                scan_tick_o <= 1'b1;
            end else begin
                scan_cnt    <= scan_cnt + 16'h0001;
                scan_tick_o <= 1'b0;
            end
            tick_dly <= {tick_dly[`PMF_EVAL_LAT-1:0], scan_tick_o};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // enable edges

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            math_en_q <= 1'b0;
            math_act  <= 1'b0;
            det_en_q  <= 1'b0;
            det_act   <= 1'b0;
        end else begin
            math_en_q <= ctrl[`PMF_CB_MATH_EN];
            det_en_q  <= ctrl[`PMF_CB_DET_EN];
            if (!ctrl[`PMF_CB_MATH_EN]) begin
                math_act <= 1'b0;
            end else if (!math_en_q) begin
                math_act <= 1'b1;
            end
            if (!ctrl[`PMF_CB_DET_EN]) begin
                det_act <= 1'b0;
            end else if (!det_en_q) begin
                det_act <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pick the highest priority among remaining operators

    always @* begin
        pick = 2'd0;
        best = prio[0];
        for (i = 1; i < 3; i = i + 1) begin
            if ((i < nops) && (prio[i] > best)) begin
                best = prio[i];
                pick = i[1:0];
            end
        end
    end

    assign pick_nx = pick + 2'd1;

    pmf_op_unit u_op (
        .opa_i   (term[pick]),
        .opb_i   (term[pick_nx]),
        .opsel_i (opr[pick]),
        .res_o   (op_res),
        .zdiv_o  (op_zd),
        .ovf_o   (op_ov)
    );

    ////////////////////////////////////////////////////////////////////////////
    // evaluation sequencer: load, three reductions, done

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state  <= ST_IDLE;
            nops   <= 2'd0;
            zd_acc <= 1'b0;
            ov_acc <= 1'b0;
            for (j = 0; j < 4; j = j + 1) begin
                term[j] <= 16'h0000;
            end
            for (j = 0; j < 3; j = j + 1) begin
                opr[j]  <= `PMF_OP_ADD;
                prio[j] <= `PMF_PR_LOW;
            end
        end else begin
            case (state)
                ST_IDLE: begin
                    if (scan_tick_o && math_act) begin
                        for (j = 0; j < 4; j = j + 1) begin
                            term[j] <= clamp16(opnd[j]);
                        end
                        for (j = 0; j < 3; j = j + 1) begin
                            opr[j]  <= oper[2*j +: 2];
                            prio[j] <= oper[`PMF_OB_PRIO + 2*j +: 2];
                        end
                        nops   <= 2'd3;
                        zd_acc <= 1'b0;
                        ov_acc <= 1'b0;
                        state  <= ST_STEP;
                    end
                end
                ST_STEP: begin
                    term[pick] <= op_res;
                    for (j = 1; j < 3; j = j + 1) begin
                        if (j > pick) begin
                            term[j] <= term[j+1];
                        end
                    end
                    for (j = 0; j < 2; j = j + 1) begin
                        if (j >= pick) begin
                            opr[j]  <= opr[j+1];
                            prio[j] <= prio[j+1];
                        end
                    end
                    zd_acc <= zd_acc | op_zd;
                    ov_acc <= ov_acc | op_ov;
                    nops   <= nops - 2'd1;
                    if (nops == 2'd1) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result and flags

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            result_value_o  <= 16'h0000;
            zero_div_flag_o <= 1'b0;
            overflow_flag_o <= 1'b0;
        end else if ((state == ST_DONE) && math_act) begin
            result_value_o  <= zd_acc ? `PMF_SAT_MAX : term[0];
            zero_div_flag_o <= zd_acc;
            overflow_flag_o <= ov_acc;
        end else if (!ctrl[`PMF_CB_MATH_EN] && !ctrl[`PMF_CB_HOLD]) begin
            result_value_o <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault detector

    assign fsel = ctrl[`PMF_CB_FSEL +: 2];

    // unit first: run after this scan's result; else at the scan tick
    assign det_exec = det_act & (ctrl[`PMF_CB_UNIT_FIRST] ?
                                 tick_dly[`PMF_EVAL_LAT] : scan_tick_o);

    always @* begin
        case (fsel)
            `PMF_FS_ZD: fault_sel = zero_div_flag_o;
            `PMF_FS_OF: fault_sel = overflow_flag_o;
            default:    fault_sel = zero_div_flag_o | overflow_flag_o;
        endcase
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_o <= 1'b0;
        end else if (!ctrl[`PMF_CB_REF_VALID]) begin
            fault_o <= 1'b0;
        end else if (ctrl[`PMF_CB_DET_RST]) begin
            fault_o <= 1'b0;
        end else if (det_exec) begin
            if (ctrl[`PMF_CB_SELF_CLR]) begin
                fault_o <= fault_sel;
            end else begin
                fault_o <= fault_o | fault_sel;
            end
        end
    end

endmodule // pmf_math_top

`default_nettype wire

// ### dv/pmf_math_monitor.sv
// checker for the priority math block, bound to its top module
// assumes one clock domain with asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module pmf_math_monitor #(
    parameter SCAN_CYCLES = 16
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [15:0] result_value_o,
    input wire logic        zero_div_flag_o,
    input wire logic        overflow_flag_o,
    input wire logic        fault_o,
    input wire logic        scan_tick_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    logic [7:0] gap;
    logic       seen;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap  <= 8'h00;
            seen <= 1'b0;
        end else begin
            gap  <= scan_tick_o ? 8'h00 : gap + 8'h01;
            seen <= seen | scan_tick_o;
        end
    end
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_has_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    rdata_stable_a: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("read data moved without ack");
    scan_period_a: assert property (seen |-> scan_tick_o == (gap == SCAN_CYCLES - 1))
        else $error("scan tick period wrong");
    zd_timing_a: assert property ($changed(zero_div_flag_o) |-> $past(scan_tick_o, 5))
        else $error("zero division flag off schedule");
    of_timing_a: assert property ($changed(overflow_flag_o) |-> $past(scan_tick_o, 5))
        else $error("overflow flag off schedule");
    res_timing_a: assert property ($changed(result_value_o) |->
        $past(scan_tick_o, 5) || result_value_o == 16'h0000)
        else $error("result moved outside evaluation");
    zd_sat_a: assert property ($rose(zero_div_flag_o) |-> result_value_o == 16'h7fff)
        else $error("zero division without saturated result");
    fault_cause_a: assert property ($rose(fault_o) |->
        $past(zero_div_flag_o || overflow_flag_o))
        else $error("fault without flag");
    zd_seen_c: cover property ($rose(zero_div_flag_o));
    of_seen_c: cover property ($rose(overflow_flag_o));
    fault_seen_c: cover property ($rose(fault_o));
endmodule // pmf_math_monitor
bind pmf_math_top pmf_math_monitor #(.SCAN_CYCLES(SCAN_CYCLES)) u_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .result_value_o(result_value_o),
    .zero_div_flag_o(zero_div_flag_o), .overflow_flag_o(overflow_flag_o),
    .fault_o(fault_o), .scan_tick_o(scan_tick_o));
`default_nettype wire

// ### dv/pmf_wb_master.sv
// wishbone classic master standing in for the controlling program
// assumes the slave answers every request with ack
`timescale 1ns/1ps
`default_nettype none
module pmf_wb_master (
    input  wire logic        clk_i,
    input  wire logic        wb_ack_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic        wb_cyc_o,
    output var  logic        wb_stb_o,
    output var  logic        wb_we_o,
    output var  logic [7:0]  wb_adr_o,
    output var  logic [3:0]  wb_sel_o,
    output var  logic [31:0] wb_dat_o
);
    initial {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
    ////////////////////////////////////////////////////////////
    // entered just after a rising edge; holds until ack is sampled
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= we;
        wb_adr_o <= adr;
        wb_sel_o <= 4'hf;
        wb_dat_o <= wd;
        @(posedge clk_i);
        while (wb_ack_i !== 1'b1) @(posedge clk_i);
        rd = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o  <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule // pmf_wb_master
`default_nettype wire

// ### dv/pmf_math_top_tb.sv
// self-checking bench for the priority math block
// assumes a short scan of 8 clocks and the register map header
`timescale 1ns/1ps
`default_nettype none
`include "pmf_map.vh"
module pmf_math_top_tb;
    typedef struct packed {
        logic [31:0] a, b, c, d;
        logic [11:0] op;
        logic [1:0]  fs;
        logic        rf;
        logic [15:0] res;
        logic        zd, of;
    } pmf_row_t;
    localparam logic [1:0] AD = `PMF_OP_ADD, SU = `PMF_OP_SUB, MU = `PMF_OP_MUL;
    localparam logic [1:0] DV = `PMF_OP_DIV, PL = `PMF_PR_LOW, PM = `PMF_PR_MED;
    localparam logic [1:0] PH = `PMF_PR_HIGH, FZ = `PMF_FS_ZD, FO = `PMF_FS_OF;
    localparam logic [1:0] FB = `PMF_FS_BOTH;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, zd, of, flt, tick;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [15:0] res;
    int err_count = 0;
    int comparisons = 0;
    int ncyc = 0;
    pmf_row_t rows [11];
    always #2.5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////
    pmf_math_top #(.SCAN_CYCLES(8)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .result_value_o(res), .zero_div_flag_o(zd),
        .overflow_flag_o(of), .fault_o(flt), .scan_tick_o(tick));
    pmf_wb_master u_master (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat),
        .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
        .wb_sel_o(sel), .wb_dat_o(wdat));
    function automatic logic [11:0] mk(input logic [1:0] o1, o2, o3, p1, p2, p3);
        return {p3, p2, p1, o3, o2, o1};
    endfunction
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_i) begin
        ncyc++;
        if (ncyc == 6000) begin
            err_count++;
            tally_and_finish;
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        u_master.xfer(1'b1, a, d, x);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        u_master.xfer(1'b0, a, 32'h0, d);
    endtask
    // raise math enable, then stop 8 edges after the next scan tick
    task run(input logic [31:0] c);
        int n;
        wr(`PMF_ADR_CTRL, c & 32'hfffffffe);
        wr(`PMF_ADR_CTRL, c);
        n = 0;
        @(posedge clk_i);
        while (tick !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        repeat (8) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        pmf_row_t r;
        logic [31:0] d;
        logic ef;
        // unused positions filled with neutral terms, one priority of each
        rows[0] = '{32'hc, 32'h6, 32'h3, 32'h1, mk(AD,DV,SU,PM,PH,PL), FB, 1'b1, 16'h000d, 1'b0, 1'b0};
        rows[1] = '{32'h2, 32'h3, 32'h1, 32'h4, mk(AD,MU,AD,PL,PM,PH), FB, 1'b1, 16'h0011, 1'b0, 1'b0};
        rows[2] = '{32'h64, 32'h19, 32'h2, 32'h1, mk(SU,DV,AD,PH,PL,PM), FB, 1'b1, 16'h0019, 1'b0, 1'b0};
        rows[3] = '{32'h5, 32'h0, 32'h0, 32'h0, mk(DV,AD,AD,PH,PM,PL), FZ, 1'b1, 16'h7fff, 1'b1, 1'b0};
        rows[4] = '{32'h12c, 32'hc8, 32'h0, 32'h0, mk(MU,AD,AD,PH,PM,PL), FZ, 1'b1, 16'h7fff, 1'b0, 1'b1};
        rows[5] = '{32'hfffffed4, 32'hc8, 32'h0, 32'h0, mk(MU,AD,AD,PH,PM,PL), FO, 1'b1, 16'h8000, 1'b0, 1'b1};
        rows[6] = '{32'h186a0, 32'h0, 32'h0, 32'h0, mk(AD,AD,AD,PH,PM,PL), FB, 1'b1, 16'h7fff, 1'b0, 1'b0};
        rows[7] = '{32'hfffe7960, 32'h0, 32'h0, 32'h0, mk(AD,AD,AD,PH,PM,PL), FB, 1'b1, 16'h8000, 1'b0, 1'b0};
        rows[8] = '{32'h5, 32'h3, 32'h0, 32'h0, mk(DV,AD,AD,PH,PM,PL), FB, 1'b1, 16'h0002, 1'b0, 1'b0};
        rows[9] = '{32'hfffffffb, 32'h3, 32'h0, 32'h0, mk(DV,AD,AD,PH,PM,PL), FB, 1'b1, 16'hfffe, 1'b0, 1'b0};
        rows[10] = '{32'h5, 32'h0, 32'h0, 32'h0, mk(DV,AD,AD,PH,PM,PL), FB, 1'b0, 16'h7fff, 1'b1, 1'b0};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("outputs after reset", 32'h0, {12'h0, res, zd, of, flt, tick});
        rd(`PMF_ADR_CTRL, d);
        chk("ctrl reset", 32'h0, d);
        rd(`PMF_ADR_OPER, d);
        chk("oper reset", 32'h180, d);
        wr(8'h20, 32'hffffffff);
        rd(8'h20, d);
        chk("unmapped read", 32'h0, d);
        $display("test reset done");
        for (int i = 0; i < 11; i++) begin
            r = rows[i];
            wr(`PMF_ADR_CTRL, 32'h0);
            chk("result when off", 32'h0, {16'h0, res});
            wr(`PMF_ADR_OPND0, r.a);
            wr(`PMF_ADR_OPND1, r.b);
            wr(`PMF_ADR_OPND2, r.c);
            wr(`PMF_ADR_OPND3, r.d);
            wr(`PMF_ADR_OPER, {20'h0, r.op});
            // unit referenced when the row's rf bit is set, executing before the detector
            run(32'h145 | {24'h0, r.rf, 1'b0, r.fs, 4'h0});
            chk("result", {16'h0, r.res}, {16'h0, res});
            chk("flags", {30'h0, r.zd, r.of}, {30'h0, zd, of});
            ef = r.rf & (r.fs == FZ ? r.zd : r.fs == FO ? r.of : r.zd | r.of);
            chk("fault", {31'h0, ef}, {31'h0, flt});
            rd(`PMF_ADR_RESULT, d);
            chk("result register", {{16{r.res[15]}}, r.res}, d);
            $display("test row %0d done", i);
        end
        wr(`PMF_ADR_CTRL, 32'h2);
        repeat (10) @(posedge clk_i);
        chk("held result", 32'h7fff, {16'h0, res});
        rd(`PMF_ADR_STATUS, d);
        chk("status while off", 32'h1, d);
        wr(`PMF_ADR_CTRL, 32'h0);
        run(32'h185);
        chk("fault on zero division", 32'h1, {31'h0, flt});
        wr(`PMF_ADR_OPND1, 32'h1);
        run(32'h185);
        chk("zero division cleared", 32'h0, {31'h0, zd});
        chk("sticky fault", 32'h1, {31'h0, flt});
        run(32'h1c5);
        chk("self cleared fault", 32'h0, {31'h0, flt});
        wr(`PMF_ADR_OPND1, 32'h0);
        run(32'h185);
        chk("fault before detector reset", 32'h1, {31'h0, flt});
        wr(`PMF_ADR_CTRL, 32'h18d);
        chk("fault after detector reset", 32'h0, {31'h0, flt});
        $display("test sticky done");
        wr(`PMF_ADR_OPND1, 32'h1);
        wr(`PMF_ADR_CTRL, 32'h0);
        run(32'hc5);
        chk("detector first sees old flag", 32'h1, {31'h0, flt});
        repeat (8) @(posedge clk_i);
        chk("detector next scan", 32'h0, {31'h0, flt});
        $display("test order done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("outputs after second reset", 32'h0, {12'h0, res, zd, of, flt, tick});
        rd(`PMF_ADR_CTRL, d);
        chk("ctrl after second reset", 32'h0, d);
        $display("test second reset done");
        tally_and_finish;
    end
endmodule // pmf_math_top_tb
`default_nettype wire
